// ---- hw/lwps_core.sv ----
// Synchronous pipelined memory core with late-write buffer and bypass.
// Assumes the bus master runs on aclk; output enable and power-down are
// asynchronous pins and are synchronised before use.
//
// How it works
// - Controls, address and data registered on rising edge
// - Data outputs updated from latches on falling edge
// - Write data arrives one cycle after address
// - Read registered, data driven the following cycle
// - Repeated same-address reads keep output steady
// - Buffered write committed on the next write
// - Byte enables pick 9-bit lanes, same timing
// - Four byte selects; none active writes nothing
// - Read address matching buffer returns buffered data
// - Bypass chosen per lane, others from array
// - Power-down floats outputs, keeps stored data
// - Wake-up recovery interval before normal operation
// - During power-down inputs ignored, lanes float
// - Output disable or deselect floats, no operation
// - Array of 131072 words of 36 bits
// - Deselect or write sampled floats after edge
`timescale 1ns/1ps
module lwps_core (
	input wire logic aclk, // Device clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [lwps_pkg::ADDR_W-1:0] sync_address_in, // Address
	input wire logic global_write_enable_n, // Global write enable
	input wire logic byte_lane0_write_n, // Lane 0 write enable
	input wire logic byte_lane1_write_n, // Lane 1 write enable
	input wire logic byte_lane2_write_n, // Lane 2 write enable
	input wire logic byte_lane3_write_n, // Lane 3 write enable
	input wire logic sync_select_n, // Synchronous select
	input wire logic async_output_enable_n, // Output enable pin
	input wire logic power_down_request, // Power-down pin
	input wire logic [lwps_pkg::DATA_W-1:0] bidir_data_bus_in, // Bus in
	output logic [lwps_pkg::DATA_W-1:0] bidir_data_bus_out, // Bus out
	output logic bidir_data_bus_oe, // High while driving bus
	input wire logic [lwps_pkg::AXI_AW-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [lwps_pkg::AXI_AW-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready // Read data ready
);
	import lwps_pkg::*;

	logic [1:0] pin_meta, pin_sync;
	logic sleep_req, oe_ok, force_sleep, active;
	lwps_state_t state, next_state;
	logic [3:0] wake_cnt, next_wake_cnt;
	logic rd_pending, next_rd_pending;
	logic wr_pending, next_wr_pending;
	logic [ADDR_W-1:0] rd_addr, next_rd_addr;
	logic [ADDR_W-1:0] wr_addr, next_wr_addr;
	logic [LANES-1:0] wr_lanes, next_wr_lanes;
	logic load_buf, commit;
	logic buf_valid, next_buf_valid;
	logic [ADDR_W-1:0] buf_addr, next_buf_addr;
	logic [LANES-1:0] buf_lanes, next_buf_lanes;
	logic [DATA_W-1:0] buf_data, next_buf_data;
	logic [DATA_W-1:0] mem [DEPTH]; // Word array
	logic [DATA_W-1:0] arr_word, rd_word;
	logic buf_hit;
	logic [DATA_W-1:0] dout, next_dout;
	logic drive_latch, next_drive_latch;

	// Two-stage synchronisers for the asynchronous pins; bit 0 power-down,
	// bit 1 output enable. Costs two cycles of reaction on both pins.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta <= 2'h2;
			pin_sync <= 2'h2;
		end else begin
			pin_meta <= {async_output_enable_n, power_down_request};
			pin_sync <= pin_meta;
		end
	end

	assign sleep_req = pin_sync[0] || force_sleep;
	assign oe_ok = !pin_sync[1];
	// Inputs count only in full run, with the output enabled, and not in
	// the cycle sleep is seen; a disabled output means no read or write
	assign active = (state == LWPS_RUN) && !sleep_req && oe_ok;

	// Power state: sleep keeps the array, wake waits out the recovery
	always_comb begin
		next_state = state;
		next_wake_cnt = wake_cnt;
		case (state)
			LWPS_RUN: begin
				if (sleep_req) begin
					next_state = LWPS_SLEEP;
				end
			end
			LWPS_SLEEP: begin
				if (!sleep_req) begin
					next_state = LWPS_WAKE;
					next_wake_cnt = WAKE_CYC;
				end
			end
			LWPS_WAKE: begin
				if (sleep_req) begin
					next_state = LWPS_SLEEP;
				end else if (wake_cnt <= 4'h1) begin
					next_state = LWPS_RUN;
				end else begin
					next_wake_cnt = wake_cnt - 4'h1;
				end
			end
			default: begin
				next_state = LWPS_SLEEP;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= LWPS_RUN;
			wake_cnt <= 4'h0;
		end else begin
			state <= next_state;
			wake_cnt <= next_wake_cnt;
		end
	end

	// Command capture on the rising edge; select high means no operation
	always_comb begin
		next_rd_pending = active && !sync_select_n &&
			global_write_enable_n;
		next_wr_pending = active && !sync_select_n &&
			!global_write_enable_n;
		next_rd_addr = next_rd_pending ? sync_address_in : rd_addr;
		next_wr_addr = next_wr_pending ? sync_address_in : wr_addr;
		next_wr_lanes = wr_lanes;
		if (next_wr_pending) begin
			next_wr_lanes = ~{byte_lane3_write_n, byte_lane2_write_n,
				byte_lane1_write_n, byte_lane0_write_n};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_pending <= 1'b0;
			wr_pending <= 1'b0;
			rd_addr <= '0;
			wr_addr <= '0;
			wr_lanes <= 4'h0;
		end else begin
			rd_pending <= next_rd_pending;
			wr_pending <= next_wr_pending;
			rd_addr <= next_rd_addr;
			wr_addr <= next_wr_addr;
			wr_lanes <= next_wr_lanes;
		end
	end

	// Data phase one cycle after the write address; the old buffer is
	// written to the array in the same edge, so reads may sit between
	assign load_buf = wr_pending && active;
	assign commit = load_buf && buf_valid;

	always_comb begin
		next_buf_valid = buf_valid;
		next_buf_addr = buf_addr;
		next_buf_lanes = buf_lanes;
		next_buf_data = buf_data;
		if (load_buf) begin
			next_buf_valid = 1'b1;
			next_buf_addr = wr_addr;
			next_buf_lanes = wr_lanes;
			next_buf_data = bidir_data_bus_in;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			buf_valid <= 1'b0;
			buf_addr <= '0;
			buf_lanes <= 4'h0;
			buf_data <= '0;
		end else begin
			buf_valid <= next_buf_valid;
			buf_addr <= next_buf_addr;
			buf_lanes <= next_buf_lanes;
			buf_data <= next_buf_data;
		end
	end

	// Array has no reset: contents survive reset and power-down alike
	always_ff @(posedge aclk) begin
		if (commit) begin
			for (int i = 0; i < LANES; i++) begin
				if (buf_lanes[i]) begin
					mem[buf_addr][i*LANE_W +: LANE_W] <=
						buf_data[i*LANE_W +: LANE_W];
				end
			end
		end
	end

	// Read word with per-lane bypass from the write buffer
	assign arr_word = mem[rd_addr];
	assign buf_hit = buf_valid && (buf_addr == rd_addr);
	always_comb begin
		rd_word = arr_word;
		for (int i = 0; i < LANES; i++) begin
			if (buf_hit && buf_lanes[i]) begin
				rd_word[i*LANE_W +: LANE_W] =
					buf_data[i*LANE_W +: LANE_W];
			end
		end
	end

	// Output latches on the falling edge; the same word is reloaded on a
	// repeated address, so the pins hold still for slow readers
	always_comb begin
		next_dout = rd_pending ? rd_word : dout;
		next_drive_latch = rd_pending;
	end

	always_ff @(negedge aclk) begin
		if (!aresetn) begin
			dout <= '0;
			drive_latch <= 1'b0;
		end else begin
			dout <= next_dout;
			drive_latch <= next_drive_latch;
		end
	end

	// Driven only in a read's data cycle; a write or deselect clears
	// rd_pending at the rising edge, so the bus floats right after it
	assign bidir_data_bus_out = dout;
	assign bidir_data_bus_oe = drive_latch && rd_pending && oe_ok &&
		(state == LWPS_RUN);

	lwps_regs u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.force_sleep(force_sleep),
		.stat_asleep(state == LWPS_SLEEP),
		.stat_waking(state == LWPS_WAKE),
		.stat_buf_valid(buf_valid),
		.stat_driving(bidir_data_bus_oe)
	);

	// Checks on the pipeline, bypass and power behaviour
	a_float_deselect: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(sync_select_n || !global_write_enable_n) |=> !bidir_data_bus_oe)
		else $error("bus driven after deselect or write edge");

	a_read_drives: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(next_rd_pending && oe_ok) ##1 (oe_ok && state == LWPS_RUN) |->
		bidir_data_bus_oe)
		else $error("read data not driven in following cycle");

	a_out_word: assert property (
		@(posedge aclk) disable iff (!aresetn)
		bidir_data_bus_oe |-> (bidir_data_bus_out == rd_word))
		else $error("driven data differs from selected read word");

	a_bypass_lane: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(bidir_data_bus_oe && buf_hit && !buf_lanes[0]) |->
		(bidir_data_bus_out[LANE_W-1:0] == mem[rd_addr][LANE_W-1:0]))
		else $error("unwritten lane not taken from array");

	a_steady_repeat: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(bidir_data_bus_oe && $past(bidir_data_bus_oe) &&
		rd_addr == $past(rd_addr) && !$past(load_buf)) |->
		$stable(bidir_data_bus_out))
		else $error("output changed on repeated read");

	a_late_data: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(wr_pending && active) |=>
		(buf_valid && buf_addr == $past(wr_addr) &&
		buf_data == $past(bidir_data_bus_in)))
		else $error("write data not captured one cycle late");

	a_write_lanes: assert property (
		@(posedge aclk) disable iff (!aresetn)
		next_wr_pending |=> (wr_pending && wr_lanes ==
		~$past({byte_lane3_write_n, byte_lane2_write_n,
		byte_lane1_write_n, byte_lane0_write_n})))
		else $error("byte lane enables not sampled with write");

	a_write_floats: assert property (
		@(posedge aclk) disable iff (!aresetn)
		wr_pending |-> !bidir_data_bus_oe)
		else $error("bus driven in write data cycle");

	a_sleep_quiet: assert property (
		@(posedge aclk) disable iff (!aresetn)
		sleep_req |=> (!bidir_data_bus_oe && !rd_pending && !wr_pending))
		else $error("activity while powered down");

	a_wake_wait: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state == LWPS_SLEEP && !sleep_req) |=> (state == LWPS_WAKE))
		else $error("run resumed without wake recovery");

	a_empty_start: assert property (
		@(posedge aclk)
		!aresetn |=> (!buf_valid && !bidir_data_bus_oe))
		else $error("write buffer not empty after reset");

	c_bypass_read: cover property (
		@(posedge aclk) disable iff (!aresetn)
		bidir_data_bus_oe && buf_hit);

	c_back_to_back_write: cover property (
		@(posedge aclk) disable iff (!aresetn)
		wr_pending && next_wr_pending && commit);

	c_sleep_wake: cover property (
		@(posedge aclk) disable iff (!aresetn)
		state == LWPS_WAKE ##1 state == LWPS_RUN);

	c_repeat_read: cover property (
		@(posedge aclk) disable iff (!aresetn)
		bidir_data_bus_oe ##1 (bidir_data_bus_oe && $stable(rd_addr)));

endmodule

// ---- hw/lwps_regs.sv ----
// AXI4-Lite slave holding the control and status words of the core.
// Assumes the master keeps at most one write and one read under way.
`timescale 1ns/1ps
module lwps_regs (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [lwps_pkg::AXI_AW-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [lwps_pkg::AXI_AW-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	output logic force_sleep, // Software power-down request
	input wire logic stat_asleep, // Core is powered down
	input wire logic stat_waking, // Core is in wake recovery
	input wire logic stat_buf_valid, // Write buffer holds a write
	input wire logic stat_driving // Data bus is being driven
);
	import lwps_pkg::*;

	logic aw_held, next_aw_held;
	logic [AXI_AW-1:0] aw_addr, next_aw_addr;
	logic w_held, next_w_held;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic [31:0] ctrl, next_ctrl;
	logic rvalid, next_rvalid;
	logic [31:0] rdata, next_rdata;
	logic [1:0] rresp, next_rresp;
	logic [31:0] status_word;

	// Ready while nothing of that channel is held and no response waits
	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready = !w_held && !bvalid;
	assign s_axi_arready = !rvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;
	assign force_sleep = ctrl[CTRL_FORCE_SLEEP_BIT];

	// Status word; bits above the flags read as zero
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[STAT_ASLEEP_BIT] = stat_asleep;
		status_word[STAT_WAKING_BIT] = stat_waking;
		status_word[STAT_BUF_VALID_BIT] = stat_buf_valid;
		status_word[STAT_DRIVING_BIT] = stat_driving;
	end

	// Write path: address and data taken in either order, then answered
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_ctrl = ctrl;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (aw_held && w_held && !bvalid) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = RESP_OKAY;
			if (aw_addr == REG_CTRL) begin
				if (w_strb[0]) begin
					next_ctrl[7:0] = w_data[7:0];
				end
			end else if (aw_addr == REG_STATUS) begin
				next_bresp = RESP_OKAY;
			end else begin
				next_bresp = RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			ctrl <= CTRL_RESET;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			ctrl <= next_ctrl;
		end
	end

	// Read path: one cycle from address to data
	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = RESP_OKAY;
			if (s_axi_araddr == REG_CTRL) begin
				next_rdata = {24'h00_0000, ctrl[7:0]};
			end else if (s_axi_araddr == REG_STATUS) begin
				next_rdata = status_word;
			end else begin
				next_rdata = 32'h0000_0000;
				next_rresp = RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else begin
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

endmodule

// ---- include/lwps_pkg.sv ----
// Shared constants and types of the late-write pipelined memory core.
// Assumes one 25 MHz clock and an AXI4-Lite master for the side registers.
package lwps_pkg;

	// Array organization: wide mode, four 9-bit lanes
	localparam int ADDR_W = 17;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = LANES * LANE_W;
	localparam int DEPTH = 131072;

	// Clock and wake-up recovery; a least time rounds up, at least one cycle
	localparam int CLK_MHZ = 25;
	localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
	localparam int WAKE_RECOVERY_NS = 8;
	localparam int WAKE_RAW = (WAKE_RECOVERY_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int WAKE_CYC_INT = (WAKE_RAW < 1) ? 1 : WAKE_RAW;
	localparam logic [3:0] WAKE_CYC = 4'(WAKE_CYC_INT);

	// Register bus layout
	localparam int AXI_AW = 4;
	localparam logic [AXI_AW-1:0] REG_CTRL = 4'h0;
	localparam logic [AXI_AW-1:0] REG_STATUS = 4'h4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int CTRL_FORCE_SLEEP_BIT = 0;
	localparam int STAT_ASLEEP_BIT = 0;
	localparam int STAT_WAKING_BIT = 1;
	localparam int STAT_BUF_VALID_BIT = 2;
	localparam int STAT_DRIVING_BIT = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Power state of the core
	typedef enum logic [1:0] {
		LWPS_RUN = 2'b00,
		LWPS_SLEEP = 2'b01,
		LWPS_WAKE = 2'b10
	} lwps_state_t;

endpackage

// ---- sim/lwps_host_model.sv ----
// Host model: turns one bench request a cycle into memory port pins.
// Assumes the bench changes req_* by non-blocking assignment at aclk rise.
`timescale 1ns/1ps
module lwps_host_model (
	input wire logic aclk, // Device clock
	input wire logic req_valid, // Offer an operation
	input wire logic req_write, // High for a write
	input wire logic [lwps_pkg::ADDR_W-1:0] req_addr, // Word address
	input wire logic [lwps_pkg::LANES-1:0] req_lanes, // Lanes to write
	input wire logic [lwps_pkg::DATA_W-1:0] req_data, // Write data
	input wire logic [lwps_pkg::DATA_W-1:0] dev_out, // Device drive
	input wire logic dev_oe, // Device drives the bus
	output logic [lwps_pkg::ADDR_W-1:0] addr = '0, // Address pins
	output logic sel_n = 1'h1, // Select, active low
	output logic we_n = 1'h1, // Write enable, active low
	output logic [lwps_pkg::LANES-1:0] lane_n = '1, // Lane enables
	output logic [lwps_pkg::DATA_W-1:0] bus, // Resolved data wire
	output logic clash // Both ends drive at once
);
	import lwps_pkg::*;
	// Mode, output clock and impedance straps sit fixed off-chip
	logic [DATA_W-1:0] held = '0;
	logic [DATA_W-1:0] wdat = '0;
	logic [DATA_W-1:0] noise = '0;
	logic drive = 1'h0;

	// Select goes low with address and controls of a valid offer
	always @(posedge aclk) begin
		sel_n <= ~req_valid;
		we_n <= ~(req_valid & req_write);
		addr <= req_addr;
		lane_n <= ~req_lanes;
		held <= req_data;
		drive <= ~sel_n & ~we_n;
		wdat <= held;
		noise <= noise + 36'h9_1234_5679;
	end

	// A released bus shows a changing pattern, never the last value
	assign bus = dev_oe ? dev_out : (drive ? wdat : noise);
	assign clash = dev_oe & drive;
endmodule

// ---- sim/tb.sv ----
// Bench for the memory core: host model on the memory port, AXI master.
// Assumes the package and the core are compiled before it.
`timescale 1ns/1ps
module tb;
	import lwps_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic oe_pin_n = 1'h0;
	logic pd_pin = 1'h0;
	logic rv = 1'h0, rw = 1'h0;
	logic [ADDR_W-1:0] ra = '0, addr;
	logic [LANES-1:0] rl = '0, lane_n;
	logic [DATA_W-1:0] rd = '0, bus, dout;
	logic sel_n, we_n, clash, oe;
	logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = '0, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
	logic [DATA_W-1:0] exp_q [$];
	logic [ADDR_W-1:0] pool [8];
	int fail_count = 0, comparisons = 0, cyc = 0;
	bit live = 1;

	// Free-running 25 MHz clock
	always #20 aclk = ~aclk;

	lwps_host_model i_host (.aclk(aclk), .req_valid(rv), .req_write(rw),
		.req_addr(ra), .req_lanes(rl), .req_data(rd), .dev_out(dout),
		.dev_oe(oe), .addr(addr), .sel_n(sel_n), .we_n(we_n),
		.lane_n(lane_n), .bus(bus), .clash(clash));

	lwps_core i_dut (.aclk(aclk), .aresetn(aresetn),
		.sync_address_in(addr), .global_write_enable_n(we_n),
		.byte_lane0_write_n(lane_n[0]), .byte_lane1_write_n(lane_n[1]),
		.byte_lane2_write_n(lane_n[2]), .byte_lane3_write_n(lane_n[3]),
		.sync_select_n(sel_n), .async_output_enable_n(oe_pin_n),
		.power_down_request(pd_pin), .bidir_data_bus_in(bus),
		.bidir_data_bus_out(dout), .bidir_data_bus_oe(oe),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	task automatic print_verdict();
		if (fail_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [DATA_W-1:0] e,
		input logic [DATA_W-1:0] s);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	// Offer one operation; the shadow merges writes at once, since a
	// later read sees them through the bypass or the array alike
	task automatic op(input bit w, input logic [ADDR_W-1:0] a,
		input logic [LANES-1:0] l, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] m;
		@(posedge aclk);
		rv <= 1'h1;
		rw <= w;
		ra <= a;
		rl <= w ? l : '0;
		rd <= d;
		m = shadow.exists(a) ? shadow[a] : '0;
		if (live && w) begin
			for (int i = 0; i < LANES; i++)
				if (l[i]) m[i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
			shadow[a] = m;
		end else if (live) begin
			exp_q.push_back(m);
		end
	endtask

	task automatic idle(input int n);
		@(posedge aclk);
		rv <= 1'h0;
		repeat (n) @(posedge aclk);
	endtask

	task automatic axw(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'h1;
		wdata <= d;
		wvalid <= 1'h1;
		bready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
			if (bvalid === 1'h1) break;
		end
		bready <= 1'h0;
		chk("bresp", DATA_W'(er), DATA_W'(bresp));
	endtask

	task automatic axr(input logic [3:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'h0;
			if (rvalid === 1'h1) break;
		end
		rready <= 1'h0;
		chk("rdata", DATA_W'(ed), DATA_W'(rdata));
		chk("rresp", DATA_W'(er), DATA_W'(rresp));
	endtask

	// Read data lands at the falling edge; look once it has settled
	always @(negedge aclk) begin
		#5;
		if (clash === 1'h1) chk("bus clash", 36'h0, 36'h1);
		if (oe !== 1'h0) begin
			if (exp_q.size() == 0) chk("stray drive", 36'h0, 36'(oe));
			else chk("read data", exp_q.pop_front(), dout);
		end
	end

	// A hang ends the run as a mismatch
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			$display("[FAIL] timeout expected 0 seen %0d", cyc);
			print_verdict();
		end
	end

	initial begin
		logic [DATA_W-1:0] d;
		void'($urandom(45));
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		idle(5);
		axr(REG_CTRL, CTRL_RESET, RESP_OKAY);
		axr(4'h8, 32'h0, RESP_SLVERR);
		axw(4'hc, 32'h1, RESP_SLVERR);
		axw(REG_STATUS, 32'hf, RESP_OKAY);
		axr(REG_STATUS, 32'h0, RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			pool[i] = ADDR_W'($urandom);
			op(1, pool[i], '1, DATA_W'({$urandom, $urandom}));
		end
		for (int i = 7; i >= 0; i--) op(0, pool[i], '0, '0);
		repeat (3) op(0, pool[3], '0, '0);
		// Each single lane, then the empty mask, read straight back
		for (int l = 0; l < 5; l++) begin
			d = DATA_W'({$urandom, $urandom});
			op(1, pool[1], LANES'(l < 4 ? 1 << l : 0), d);
			op(0, pool[1], '0, '0);
		end
		for (int i = 0; i < 60; i++) begin
			d = DATA_W'({$urandom, $urandom});
			op(1'($urandom_range(1)), pool[$urandom_range(7)],
				LANES'($urandom), d);
		end
		idle(3);
		// Output enable pin high: a read must leave the bus alone
		oe_pin_n <= 1'h1;
		idle(4);
		live = 0;
		op(1, pool[0], '1, '0);
		op(0, pool[0], '0, '0);
		idle(2);
		oe_pin_n <= 1'h0;
		idle(4);
		live = 1;
		// Power-down pin: ops ignored, contents kept after recovery
		pd_pin <= 1'h1;
		idle(4);
		axr(REG_STATUS, 32'h5, RESP_OKAY);
		live = 0;
		op(1, pool[2], '1, '0);
		op(0, pool[2], '0, '0);
		idle(3);
		pd_pin <= 1'h0;
		idle(4 + WAKE_CYC_INT);
		live = 1;
		axr(REG_STATUS, 32'h4, RESP_OKAY);
		for (int i = 0; i < 8; i++) op(0, pool[i], '0, '0);
		idle(2);
		// Software sleep through the control word
		axw(REG_CTRL, 32'h1, RESP_OKAY);
		axr(REG_CTRL, 32'h1, RESP_OKAY);
		axr(REG_STATUS, 32'h5, RESP_OKAY);
		live = 0;
		op(0, pool[4], '0, '0);
		idle(2);
		axw(REG_CTRL, 32'h0, RESP_OKAY);
		idle(4);
		live = 1;
		op(0, pool[4], '0, '0);
		idle(6);
		chk("pending reads", 36'h0, 36'(exp_q.size()));
		print_verdict();
	end
endmodule
